// [verilog/led_scan_consts.vh]
// Purpose: named constants for the led matrix scan and scroll control
// Assumes: register index times four gives the axi byte address
// Notes: definitions only
`ifndef LED_SCAN_CONSTS_VH
`define LED_SCAN_CONSTS_VH
// register indices
`define IDX_SCROLL_CTRL 8'h75
`define IDX_SCROLL_PERIOD 8'h76
`define IDX_FORCE_LOW 8'h77
`define IDX_FORCE_HIGH 8'h78
`define IDX_MASK_LOW 8'h79
`define IDX_MASK_HIGH 8'h7A
`define IDX_COLUMN_COUNT 8'h7E
`define IDX_MODE_CTRL 8'h80
`define IDX_STATUS 8'h81
// reset values
`define RST_BYTE 8'h00
`define RST_COLUMN_COUNT 8'h0B
`define RST_MODE_CTRL 8'h00
// scroll control and scroll period fields
`define LEFT_BIT 0
`define UP_BIT 1
`define HOLD_LSB 2
`define HOLD_MSB 6
`define PERIOD_MSB 2
// mask high and force high fields
`define MASK_LEVEL_BIT 4
`define MASK_HIGH_MSB 3
`define FORCE_HIGH_MSB 4
// mode control fields
`define EN_BIT 0
`define OPMODE_LSB 1
`define OPMODE_MSB 2
`define EXTCLK_BIT 3
`define OPMODE_SCROLL 2'b11
// column count
`define COLCNT_MSB 3
`define COLCNT_ALL 4'hB
`define NCOLS 4'hC
// line modes
`define LM_OFF 2'b00
`define LM_CONST 2'b01
`define LM_PWM 2'b10
`define LM_FIREFLY 2'b11
`define SLOPE_CONST 3'h0
// timing
`define MCLK_MHZ 125
`define MCLK_KHZ 125000
`define OSC_KHZ 2400
`define OSC_DIV ((`MCLK_KHZ + `OSC_KHZ - 1) / `OSC_KHZ)
`define SCAN_SLOT_TICKS 1024
`define SCAN_GAP_TICKS 4
`define SCROLL_STEP_US 25000
`define SCROLL_STEP_CYCLES (`SCROLL_STEP_US * `MCLK_MHZ)
// axi responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// [verilog/scan_sequencer.v]
// Purpose: walks the scan switches one column at a time
// Assumes: tick is a one-cycle pulse at the scan clock rate
// Notes: gap is high during the leading interval of each slot
`timescale 1ns/1ps
`default_nettype none
`include "led_scan_consts.vh"
module scan_sequencer #(
   parameter SLOT_TICKS = `SCAN_SLOT_TICKS,
   parameter GAP_TICKS = `SCAN_GAP_TICKS
) (
   input wire mclk,
   input wire rst_n,
   input wire tick,
   input wire [3:0] ncols,
   output reg [3:0] col,
   output reg gap
);
   reg [10:0] slot;
   // slot counter; column advances only at slot end so a count change never cuts a slot
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         slot <= 11'h000;
         col <= 4'h0;
         gap <= 1'b1;
      end else if (tick) begin
         if (slot == SLOT_TICKS - 1) begin
            slot <= 11'h000;
            gap <= 1'b1;
            if (col >= ncols - 4'h1)
               col <= 4'h0;
            else
               col <= col + 4'h1;
         end else begin
            slot <= slot + 11'h001;
            gap <= (slot + 11'h001) < GAP_TICKS;
         end
      end
   end
endmodule // scan_sequencer
`default_nettype wire

// [verilog/scroll_step_timer.v]
// Purpose: one-cycle step pulse every (code+1) scroll time units
// Assumes: run low holds the timer at zero
// Notes: unit length is a parameter so benches can shorten it
`timescale 1ns/1ps
`default_nettype none
`include "led_scan_consts.vh"
module scroll_step_timer #(
   parameter UNIT_CYCLES = `SCROLL_STEP_CYCLES,
   parameter CW = 22
) (
   input wire mclk,
   input wire rst_n,
   input wire run,
   input wire [2:0] period_code,
   output reg step
);
   reg [CW-1:0] cyc;
   reg [2:0] units;
   // linear period: unit count compared against the live code
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cyc <= {CW{1'b0}};
         units <= 3'h0;
         step <= 1'b0;
      end else if (!run) begin
         cyc <= {CW{1'b0}};
         units <= 3'h0;
         step <= 1'b0;
      end else if (cyc == UNIT_CYCLES - 1) begin
         cyc <= {CW{1'b0}};
         if (units >= period_code) begin
            units <= 3'h0;
            step <= 1'b1;
         end else begin
            units <= units + 3'h1;
            step <= 1'b0;
         end
      end else begin
         cyc <= cyc + {{(CW-1){1'b0}}, 1'b1};
         step <= 1'b0;
      end
   end
endmodule // scroll_step_timer
`default_nettype wire

// [verilog/led_scan_scroll_ctrl.v]
// Purpose: scan, scroll, forcing and mask control for a 12x12 led matrix
// Assumes: axi4-lite register access; pwm enables and slope codes come from mclk logic
// Notes: scan switch control is active low (low turns the supply switch on)
// Operation
// - row hold bits A..E keep a row stationary during scroll when set
// - up bit selects upward scrolling; cleared means no upward scroll
// - left bit selects leftward scrolling; cleared means no leftward scroll
// - row hold bits are ignored while scrolling upward
// - in scroll mode every lit line runs constant current
// - both direction bits set scrolls left only
// - step time is 25 ms times (code plus one)
// - force low bits pin lines Z1..Z8 to constant current
// - force high bits 0..4 pin lines Z9..Z13 to constant current
// - mask low bits drive scan controls 1..8 to the mask level
// - mask high bits 0..3 drive scan controls 9..12 to the mask level
// - mask level bit: zero drives masked controls low, one drives high
// - constant current forcing overrides the scan mask
// - column count code n scans the first n+1 columns; 0Bh scans all
// - only bits 3:0 of the code are used; values 0Bh..0Fh there scan all columns
// - column count ignored during scroll or open/short detection
// - line mode: off, forced constant, pwm, firefly, else constant current
// - scan runs from internal 2.4 MHz tick or external clock pin
// - scan controls on one at a time, 1024 clocks with 4-clock gap
`timescale 1ns/1ps
`default_nettype none
`include "led_scan_consts.vh"
module led_scan_scroll_ctrl #(
   parameter STEP_CYCLES = `SCROLL_STEP_CYCLES,
   parameter NLINES = 13,
   parameter NCOLS = 12
) (
   input wire mclk,
   input wire nrst,
   input wire [9:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [9:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire clock_in_out_pin,
   input wire detect_en,
   input wire [NLINES-1:0] line_pwm_en,
   input wire [3*NLINES-1:0] driver_slope_code,
   output reg [NCOLS-1:0] scan_switch_ctrl,
   output reg [2*NLINES-1:0] sink_ctrl,
   output reg [4*NCOLS-1:0] row_col_offset,
   output reg [3:0] row_offset
);
   reg rst_meta;
   reg rst_n;
   reg [7:0] scroll_control;
   reg [7:0] scroll_period;
   reg [7:0] line_force_const_low;
   reg [7:0] line_force_const_high;
   reg [7:0] scan_switch_mask_low;
   reg [7:0] scan_switch_mask_high;
   reg [7:0] column_scan_count;
   reg [7:0] mode_ctrl;
   reg [7:0] aw_idx;
   reg aw_held;
   reg [7:0] w_byte;
   reg w_held;
   reg clk_meta;
   reg clk_sync;
   reg clk_prev;
   reg [5:0] osc_div;
   reg osc_tick;
   reg scan_tick;
   reg [2*NLINES-1:0] next_sink_ctrl;
   reg [NCOLS-1:0] next_scan;
   reg [31:0] next_rdata;
   reg next_rerr;
   reg next_werr;
   reg [3:0] ncols;
   wire [3:0] col;
   wire gap;
   wire step;
   wire [7:0] ar_idx;
   wire [12:0] force_bits;
   wire [11:0] mask_bits;
   wire matrix_enable;
   wire [1:0] matrix_op_mode;
   wire scroll_mode;
   wire go_left;
   wire go_up;
   wire [3:0] colcnt;
   wire [NCOLS-1:0] row_hold;
   reg w_seen;
   integer i;
   integer j;
   integer k;

   // reset release through two flops
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   assign ar_idx = s_axi_araddr[9:2];
   assign force_bits = {line_force_const_high[`FORCE_HIGH_MSB:0], line_force_const_low};
   assign mask_bits = {scan_switch_mask_high[`MASK_HIGH_MSB:0], scan_switch_mask_low};
   assign matrix_enable = mode_ctrl[`EN_BIT];
   assign matrix_op_mode = mode_ctrl[`OPMODE_MSB:`OPMODE_LSB];
   assign scroll_mode = matrix_enable && (matrix_op_mode == `OPMODE_SCROLL);
   assign colcnt = column_scan_count[`COLCNT_MSB:0];
   // hold bits widened to one per row so rows F..L can never read past the field
   assign row_hold = {{(NCOLS-`HOLD_MSB+`HOLD_LSB-1){1'b0}}, scroll_control[`HOLD_MSB:`HOLD_LSB]};
   // left wins when both are set
   assign go_left = scroll_mode && scroll_control[`LEFT_BIT];
   assign go_up = scroll_mode && scroll_control[`UP_BIT] && !scroll_control[`LEFT_BIT];

   // write address and data are caught independently, then committed together
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         aw_idx <= 8'h00;
         aw_held <= 1'b0;
         w_byte <= 8'h00;
         w_held <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready <= !w_seen && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_idx <= s_axi_awaddr[9:2];
            aw_held <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_byte <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
            w_held <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end
         if (aw_held && w_seen) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
         end
      end
   end

   // strobe-less data beat still needs a response; track it apart from the byte
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         w_seen <= 1'b0;
      else if (s_axi_wvalid && s_axi_wready)
         w_seen <= 1'b1;
      else if (aw_held && w_seen)
         w_seen <= 1'b0;
   end

   // unmapped index answers slverr
   always @* begin
      next_werr = 1'b0;
      if (aw_idx == `IDX_SCROLL_CTRL) next_werr = 1'b0;
      else if (aw_idx == `IDX_SCROLL_PERIOD) next_werr = 1'b0;
      else if (aw_idx == `IDX_FORCE_LOW) next_werr = 1'b0;
      else if (aw_idx == `IDX_FORCE_HIGH) next_werr = 1'b0;
      else if (aw_idx == `IDX_MASK_LOW) next_werr = 1'b0;
      else if (aw_idx == `IDX_MASK_HIGH) next_werr = 1'b0;
      else if (aw_idx == `IDX_COLUMN_COUNT) next_werr = 1'b0;
      else if (aw_idx == `IDX_MODE_CTRL) next_werr = 1'b0;
      else if (aw_idx == `IDX_STATUS) next_werr = 1'b0;
      else next_werr = 1'b1;
   end

   // register writes; status index is read only and ignores writes
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         scroll_control <= `RST_BYTE;
         scroll_period <= `RST_BYTE;
         line_force_const_low <= `RST_BYTE;
         line_force_const_high <= `RST_BYTE;
         scan_switch_mask_low <= `RST_BYTE;
         scan_switch_mask_high <= `RST_BYTE;
         column_scan_count <= `RST_COLUMN_COUNT;
         mode_ctrl <= `RST_MODE_CTRL;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else begin
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (aw_held && w_seen && !s_axi_bvalid) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= next_werr ? `RESP_SLVERR : `RESP_OKAY;
            if (w_held) begin
               if (aw_idx == `IDX_SCROLL_CTRL) scroll_control <= w_byte;
               else if (aw_idx == `IDX_SCROLL_PERIOD) scroll_period <= w_byte;
               else if (aw_idx == `IDX_FORCE_LOW) line_force_const_low <= w_byte;
               else if (aw_idx == `IDX_FORCE_HIGH) line_force_const_high <= w_byte;
               else if (aw_idx == `IDX_MASK_LOW) scan_switch_mask_low <= w_byte;
               else if (aw_idx == `IDX_MASK_HIGH) scan_switch_mask_high <= w_byte;
               else if (aw_idx == `IDX_COLUMN_COUNT) column_scan_count <= w_byte;
               else if (aw_idx == `IDX_MODE_CTRL) mode_ctrl <= w_byte;
            end
         end
      end
   end

   // read mux; status shows live scan column, gap and vertical offset
   always @* begin
      next_rdata = 32'h00000000;
      next_rerr = 1'b0;
      if (ar_idx == `IDX_SCROLL_CTRL) next_rdata[7:0] = scroll_control;
      else if (ar_idx == `IDX_SCROLL_PERIOD) next_rdata[7:0] = scroll_period;
      else if (ar_idx == `IDX_FORCE_LOW) next_rdata[7:0] = line_force_const_low;
      else if (ar_idx == `IDX_FORCE_HIGH) next_rdata[7:0] = line_force_const_high;
      else if (ar_idx == `IDX_MASK_LOW) next_rdata[7:0] = scan_switch_mask_low;
      else if (ar_idx == `IDX_MASK_HIGH) next_rdata[7:0] = scan_switch_mask_high;
      else if (ar_idx == `IDX_COLUMN_COUNT) next_rdata[7:0] = column_scan_count;
      else if (ar_idx == `IDX_MODE_CTRL) next_rdata[7:0] = mode_ctrl;
      else if (ar_idx == `IDX_STATUS) next_rdata[8:0] = {gap, row_offset, col};
      else next_rerr = 1'b1;
   end

   // one read at a time: arready drops until the data beat is taken
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rerr ? `RESP_SLVERR : `RESP_OKAY;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // scan clock: internal divider or rising edges of the synced external pin
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         clk_meta <= 1'b0;
         clk_sync <= 1'b0;
         clk_prev <= 1'b0;
         osc_div <= 6'h00;
         osc_tick <= 1'b0;
         scan_tick <= 1'b0;
      end else begin
         clk_meta <= clock_in_out_pin;
         clk_sync <= clk_meta;
         clk_prev <= clk_sync;
         osc_tick <= (osc_div == `OSC_DIV - 1);
         if (osc_div == `OSC_DIV - 1)
            osc_div <= 6'h00;
         else
            osc_div <= osc_div + 6'h01;
         if (mode_ctrl[`EXTCLK_BIT])
            scan_tick <= clk_sync && !clk_prev;
         else
            scan_tick <= osc_tick;
      end
   end

   // scanned column count; scroll and detection always use all columns
   always @* begin
      if (scroll_mode || detect_en)
         ncols = `NCOLS;
      else if (colcnt >= `COLCNT_ALL)
         ncols = `NCOLS;
      else
         ncols = colcnt + 4'h1;
   end

   scan_sequencer u_scan (
      .mclk(mclk),
      .rst_n(rst_n),
      .tick(scan_tick),
      .ncols(ncols),
      .col(col),
      .gap(gap)
   );

   scroll_step_timer #(.UNIT_CYCLES(STEP_CYCLES)) u_step (
      .mclk(mclk),
      .rst_n(rst_n),
      .run(go_left || go_up),
      .period_code(scroll_period[`PERIOD_MSB:0]),
      .step(step)
   );

   // active-low scan controls: one on per slot, mask applies unless line forced
   always @* begin
      next_scan = {NCOLS{1'b1}};
      for (i = 0; i < NCOLS; i = i + 1) begin
         if (matrix_enable && !gap && col == i[3:0])
            next_scan[i] = 1'b0;
         if (mask_bits[i] && !force_bits[i])
            next_scan[i] = scan_switch_mask_high[`MASK_LEVEL_BIT];
      end
   end

   // per-line mode in priority order
   always @* begin
      next_sink_ctrl = {2*NLINES{1'b0}};
      for (j = 0; j < NLINES; j = j + 1) begin
         if (!matrix_enable)
            next_sink_ctrl[2*j +: 2] = `LM_OFF;
         else if (force_bits[j])
            next_sink_ctrl[2*j +: 2] = `LM_CONST;
         else if (scroll_mode)
            next_sink_ctrl[2*j +: 2] = `LM_CONST;
         else if (line_pwm_en[j])
            next_sink_ctrl[2*j +: 2] = `LM_PWM;
         else if (driver_slope_code[3*j +: 3] != `SLOPE_CONST)
            next_sink_ctrl[2*j +: 2] = `LM_FIREFLY;
         else
            next_sink_ctrl[2*j +: 2] = `LM_CONST;
      end
   end

   // registered matrix outputs
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         scan_switch_ctrl <= {NCOLS{1'b1}};
         sink_ctrl <= {2*NLINES{1'b0}};
      end else begin
         scan_switch_ctrl <= next_scan;
         sink_ctrl <= next_sink_ctrl;
      end
   end

   // pattern shift: held rows A..E freeze on left scroll only; up moves all rows
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         row_col_offset <= {4*NCOLS{1'b0}};
         row_offset <= 4'h0;
      end else if (step) begin
         if (go_left) begin
            for (k = 0; k < NCOLS; k = k + 1) begin
               if (!row_hold[k]) begin
                  if (row_col_offset[4*k +: 4] == `NCOLS - 4'h1)
                     row_col_offset[4*k +: 4] <= 4'h0;
                  else
                     row_col_offset[4*k +: 4] <= row_col_offset[4*k +: 4] + 4'h1;
               end
            end
         end else if (go_up) begin
            if (row_offset == `NCOLS - 4'h1)
               row_offset <= 4'h0;
            else
               row_offset <= row_offset + 4'h1;
         end
      end
   end
endmodule // led_scan_scroll_ctrl
`default_nettype wire

// [verif/led_scan_scroll_properties.sv]
// Purpose: port checks for the led scan and scroll control
// Assumes: lines 0 and 1 stand for every sink line
// Notes: bound to the top module below
`timescale 1ns/1ps
`default_nettype none
`include "led_scan_consts.vh"
module led_scan_scroll_properties #(
   parameter NLINES = 13
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [NLINES-1:0] line_pwm_en,
   input wire logic [3*NLINES-1:0] driver_slope_code,
   input wire logic [2*NLINES-1:0] sink_ctrl,
   input wire logic [3:0] row_offset
);
   logic slow1;
   // line 1 may fade only on its own slope with pwm off
   assign slow1 = !line_pwm_en[1] && driver_slope_code[5:3] != `SLOPE_CONST;
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer not held");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
   write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> !s_axi_bvalid ##2 s_axi_bvalid) else $error("write answer late");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");
   pwm_cause_a: assert property (sink_ctrl[1:0] == `LM_PWM
      |-> $past(line_pwm_en[0]) || $past(line_pwm_en[0], 2)) else $error("pwm without enable");
   firefly_cause_a: assert property (sink_ctrl[3:2] == `LM_FIREFLY
      |-> $past(slow1) || $past(slow1, 2)) else $error("firefly without slope");
   row_step_a: assert property ($changed(row_offset) && row_offset != 4'h0
      && $past(row_offset) != 4'h0 |-> row_offset == $past(row_offset) + 4'h1
      || row_offset + 4'h1 == $past(row_offset)) else $error("row offset jumped");
endmodule // led_scan_scroll_properties
bind led_scan_scroll_ctrl led_scan_scroll_properties #(.NLINES(NLINES)) props_u (.mclk, .nrst,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
   .line_pwm_en, .driver_slope_code, .sink_ctrl, .row_offset);
`default_nettype wire

// [verif/led_matrix_model.sv]
// Purpose: matrix side, timing each lit column
// Assumes: a supply switch is on while its control is low
// Notes: slot_len runs start to start, dark_len is the lead-in
`timescale 1ns/1ps
`default_nettype none
module led_matrix_model #(
   parameter NCOLS = 12
) (
   input wire logic mclk,
   input wire logic [NCOLS-1:0] scan_switch_ctrl,
   output var int slot_len,
   output var int dark_len
);
   int run = 0;
   int dark = 0;
   logic was_dark = 1'h1;
   // a column lighting after darkness opens a new slot
   always @(posedge mclk) begin
      was_dark <= &scan_switch_ctrl;
      run <= run + 1;
      if (&scan_switch_ctrl) begin
         dark <= dark + 1;
      end else if (was_dark) begin
         slot_len <= run + 1;
         dark_len <= dark;
         run <= 0;
         dark <= 0;
      end
   end
endmodule // led_matrix_model
`default_nettype wire

// [verif/led_matrix_scan_scroll_control_bench.sv]
// Purpose: register bench for the led scan and scroll control
// Assumes: scan clock pin toggles at a quarter of mclk
// Notes: scroll unit cut to STEP cycles to keep the run short
`timescale 1ns/1ps
`default_nettype none
`include "led_scan_consts.vh"
module led_matrix_scan_scroll_control_bench;
   localparam int STEP = 20;
   localparam int SLOT = 4096; // 1024 ticks of four cycles
   logic mclk = 1'h0, nrst = 1'h0, pin = 1'h0, detect = 1'h0, multi;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [1:0] div = 2'h0, rs;
   logic [9:0] awaddr = 10'h0, araddr = 10'h0;
   logic [31:0] wdata = 32'h0, rd;
   logic [12:0] pwm_en = 13'h0;
   logic [38:0] slope = 39'h0;
   logic [11:0] seen;
   wire logic awready, wready, bvalid, arready, rvalid;
   wire logic [1:0] bresp, rresp;
   wire logic [31:0] rdata;
   wire logic [11:0] sw;
   wire logic [25:0] sink;
   wire logic [47:0] colofs;
   wire logic [3:0] rowofs;
   int slot_len, dark_len, n, miscompares = 0, tests_run = 0;
   logic [7:0] idx_t [7] = '{`IDX_SCROLL_CTRL, `IDX_SCROLL_PERIOD, `IDX_FORCE_LOW,
      `IDX_FORCE_HIGH, `IDX_MASK_LOW, `IDX_MASK_HIGH, `IDX_COLUMN_COUNT};
   logic [7:0] pat_t [7] = '{8'h7F, 8'h07, 8'hFF, 8'h1F, 8'hFF, 8'h1F, 8'h0F};
   led_scan_scroll_ctrl #(.STEP_CYCLES(STEP)) dut_u (
      .mclk(mclk), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .clock_in_out_pin(pin), .detect_en(detect), .line_pwm_en(pwm_en),
      .driver_slope_code(slope), .scan_switch_ctrl(sw), .sink_ctrl(sink),
      .row_col_offset(colofs), .row_offset(rowofs));
   led_matrix_model model_u (.mclk(mclk), .scan_switch_ctrl(sw), .slot_len(slot_len),
      .dark_len(dark_len));
   // system clock
   initial begin
      forever #4 mclk = ~mclk;
   end
   // external scan clock, four mclk per period
   always @(posedge mclk) begin
      div <= div + 2'h1;
      pin <= div[1];
   end
   task automatic check(input logic [33:0] seen_v, input logic [33:0] exp_v);
      tests_run++;
      if (seen_v !== exp_v) begin
         miscompares++;
         $display("ERROR %0t seen %h expected %h", $time, seen_v, exp_v);
      end
   endtask
   task automatic report_and_stop;
      if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // write and read hold every channel until its own handshake edge
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic a, w;
      @(posedge mclk);
      awaddr <= {idx, 2'h0};
      wdata <= {24'h0, d};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      a = 1'h0;
      w = 1'h0;
      while (!(a && w)) begin
         @(posedge mclk);
         if (awvalid && awready) begin
            a = 1'h1;
            awvalid <= 1'h0;
         end
         if (wvalid && wready) begin
            w = 1'h1;
            wvalid <= 1'h0;
         end
      end
      while (!bvalid) @(posedge mclk);
      rs = bresp;
      bready <= 1'h0;
   endtask
   task automatic rdr(input logic [7:0] idx);
      @(posedge mclk);
      araddr <= {idx, 2'h0};
      arvalid <= 1'h1;
      rready <= 1'h1;
      @(posedge mclk);
      while (!arready) @(posedge mclk);
      arvalid <= 1'h0;
      while (!rvalid) @(posedge mclk);
      rd = rdata;
      rs = rresp;
      rready <= 1'h0;
   endtask
   // expected mode of each sink line, by priority
   function automatic logic [25:0] modes(input logic en, input logic scr, input logic [12:0] f);
      logic [25:0] m;
      for (int i = 0; i < 13; i++) begin
         if (!en) m[2*i+:2] = `LM_OFF;
         else if (f[i] || scr) m[2*i+:2] = `LM_CONST;
         else if (pwm_en[i]) m[2*i+:2] = `LM_PWM;
         else if (slope[3*i+:3] != `SLOPE_CONST) m[2*i+:2] = `LM_FIREFLY;
         else m[2*i+:2] = `LM_CONST;
      end
      return m;
   endfunction
   // second interval between offset changes; the first may be cut short
   task automatic step_time(input int sel, output int cyc);
      logic [3:0] v;
      for (int k = 0; k < 2; k++) begin
         v = sel ? rowofs : colofs[7:4];
         cyc = 0;
         while ((sel ? rowofs : colofs[7:4]) === v && cyc < 4000) begin
            @(posedge mclk);
            cyc++;
         end
      end
   endtask
   task automatic watch(input int slots);
      seen = 12'h0;
      multi = 1'h0;
      repeat (slots * SLOT) begin
         @(posedge mclk);
         seen = seen | ~sw;
         if ($countones(~sw) > 1) multi = 1'h1;
      end
   endtask
   initial begin
      repeat (16) @(posedge mclk);
      nrst <= 1'h1;
      pwm_en <= 13'h1209;
      slope <= 39'h50_0000_0018;
      repeat (4) @(posedge mclk);
      // reset value, write and read back of every register except mode control and status
      for (int i = 0; i < 7; i++) begin
         rdr(idx_t[i]);
         check({rs, rd}, {2'h0, 24'h0, (i == 6) ? 8'h0B : 8'h00});
         wr(idx_t[i], pat_t[i]);
         rdr(idx_t[i]);
         check(rd, {24'h0, pat_t[i]});
         wr(idx_t[i], 8'h00);
      end
      wr(8'h7B, 8'h55);
      check(rs, `RESP_SLVERR);
      rdr(8'h7B);
      check({rs, rd}, {`RESP_SLVERR, 32'h0});
      check(sink, modes(1'h0, 1'h0, 13'h0));
      wr(`IDX_MODE_CTRL, 8'h01);
      repeat (4) @(posedge mclk);
      check(sink, modes(1'h1, 1'h0, 13'h0));
      wr(`IDX_FORCE_LOW, 8'h08);
      wr(`IDX_FORCE_HIGH, 8'h11);
      repeat (4) @(posedge mclk);
      check(sink, modes(1'h1, 1'h0, 13'h1108));
      wr(`IDX_FORCE_HIGH, 8'h00);
      wr(`IDX_SCROLL_CTRL, 8'h05);
      wr(`IDX_MODE_CTRL, 8'h07);
      repeat (4) @(posedge mclk);
      check(sink, modes(1'h1, 1'h1, 13'h0));
      // every period code, scrolling left with row A held
      for (int p = 0; p < 8; p++) begin
         wr(`IDX_SCROLL_PERIOD, p[7:0]);
         step_time(0, n);
         check(n, (p + 1) * STEP);
      end
      check({colofs[3:0], rowofs}, 8'h00);
      wr(`IDX_SCROLL_CTRL, 8'h03);
      step_time(0, n);
      check({n[15:0], rowofs}, {16'(8 * STEP), 4'h0});
      wr(`IDX_SCROLL_CTRL, 8'h06);
      step_time(1, n);
      check(n, 8 * STEP);
      wr(`IDX_SCROLL_CTRL, 8'h00);
      wr(`IDX_MODE_CTRL, 8'h00);
      wr(`IDX_MASK_LOW, 8'h28);
      wr(`IDX_MASK_HIGH, 8'h01);
      repeat (4) @(posedge mclk);
      check(sw, 12'hEDF);
      // scanning on the pin clock, column 2 masked off
      wr(`IDX_MASK_LOW, 8'h04);
      wr(`IDX_MASK_HIGH, 8'h10);
      wr(`IDX_COLUMN_COUNT, 8'h01);
      wr(`IDX_MODE_CTRL, 8'h09);
      watch(3);
      check({multi, seen}, 13'h0003);
      check({slot_len[15:0], dark_len[15:0]}, {16'(SLOT), 16'h0010});
      detect <= 1'h1;
      watch(4);
      check({seen[3], seen[2]}, 2'h2);
      wr(`IDX_COLUMN_COUNT, 8'h0C);
      detect <= 1'h0;
      watch(4);
      check(|seen[11:4], 1'h1);
      report_and_stop;
   end
   // cut a hang short well past the expected run
   initial begin
      #700_000;
      miscompares++;
      report_and_stop;
   end
endmodule // led_matrix_scan_scroll_control_bench
`default_nettype wire
